// [verilog/otc_pkg.sv]
/*
 * Constants and carrier types for the oscillator trim control registers.
 * Assumes a 32-bit AXI4-Lite slave port and one synchronous clock domain.
 */
package otc_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] OTC_OFF_FAST_RC   = 12'h010;
    localparam logic [11:0] OTC_OFF_AUX_RC    = 12'h018;
    localparam logic [11:0] OTC_OFF_SLOW_RC   = 12'h020;
    localparam logic [11:0] OTC_OFF_XTAL      = 12'h024;
    localparam logic [11:0] OTC_OFF_STATUS    = 12'h040;
    localparam logic [11:0] OTC_OFF_POWER     = 12'h044;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int OTC_TUNE_LSB   = 0;
    localparam int OTC_FINE_LSB   = 8;
    localparam int OTC_BAND_LSB   = 16;
    localparam int OTC_CMPB_LSB   = 21;
    localparam int OTC_HIPWR_BIT  = 24;
    localparam int OTC_DIV_LSB    = 25;
    localparam int OTC_FINEEN_BIT = 27;
    localparam int OTC_VREF_LSB   = 28;
    localparam int OTC_AUTOSW_BIT = 29;
    localparam int OTC_AUTOST_BIT = 28;

    // Writable bit masks; reserved bits stay zero
    localparam logic [31:0] OTC_RC_MASK    = 32'hffff_3f7f;
    localparam logic [31:0] OTC_SLOW_MASK  = 32'hf307_01ff;
    localparam logic [31:0] OTC_XTAL_MASK  = 32'h3700_0730;

    // Reset values
    localparam logic [31:0] OTC_RC_RESET   = 32'hb148_1f3c;
    localparam logic [31:0] OTC_SLOW_RESET = 32'h8106_0100;
    localparam logic [31:0] OTC_XTAL_RESET = 32'h0000_0000;

    // Sync pending length plus one; the status flag stays set for three cycles
    localparam int OTC_SYNC_CYCLES = 4;

    // Divider codes
    localparam logic [1:0] OTC_DIV_ONE  = 2'h0;
    localparam logic [1:0] OTC_DIV_TWO  = 2'h1;
    localparam logic [1:0] OTC_DIV_FOUR = 2'h2;

    // AXI responses
    localparam logic [1:0] OTC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] OTC_RESP_SLVERR = 2'h2;

    // Trim settings handed to one RC oscillator
    typedef struct packed {
        logic [3:0] vref_tc;
        logic       fine_trim_enable;
        logic [1:0] osc_output_divider;
        logic       regulator_high_power;
        logic [2:0] cmp_bias;
        logic [4:0] band_select;
        logic [5:0] fine_trim_value;
        logic [6:0] coarse_trim;
    } otc_rc_trim_t;

    typedef enum logic [1:0] {
        OTC_AS_IDLE  = 2'b00,
        OTC_AS_START = 2'b01,
        OTC_AS_SWAP  = 2'b10
    } otc_auto_t;

endpackage

// [verilog/otc_rc_field.sv]
/*
 * Unpacks one RC oscillator control word and applies its gating.
 * Assumes a word with reserved bits already cleared.
 */
`timescale 1ns/1ps
module otc_rc_field (
    input  wire logic [31:0]          ctrl_word,
    output otc_pkg::otc_rc_trim_t     trim,
    output logic [5:0]                eff_fine
);
    import otc_pkg::*;

    // ------------------------------------------------------------
    // Field unpack
    // ------------------------------------------------------------
    always_comb begin
        trim.vref_tc              = ctrl_word[OTC_VREF_LSB +: 4];
        trim.fine_trim_enable     = ctrl_word[OTC_FINEEN_BIT];
        trim.osc_output_divider   = ctrl_word[OTC_DIV_LSB +: 2];
        trim.regulator_high_power = ctrl_word[OTC_HIPWR_BIT];
        trim.cmp_bias             = ctrl_word[OTC_CMPB_LSB +: 3];
        trim.band_select          = ctrl_word[OTC_BAND_LSB +: 5];
        trim.fine_trim_value      = ctrl_word[OTC_FINE_LSB +: 6];
        trim.coarse_trim          = ctrl_word[OTC_TUNE_LSB +: 7];
    end

    // Fine value is only seen by the analog side when enabled
    assign eff_fine = trim.fine_trim_enable ?
                      trim.fine_trim_value : 6'h00; // [R4]

endmodule

// [verilog/otc_regs.sv]
/*
 * Oscillator trim and control register file with clock dividers and
 * crystal auto-start sequencing.
 * Assumes an AXI4-Lite master on sys_clk and oscillator clocks that are
 * sampled as enables in this domain.
 */
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
// Contract
// [R1] Fast RC divider codes 0,1,2 divide by 1,2,4, reset divide-by-one.
// [R2] Auxiliary RC has its own divider, same codes, reset divide-by-one.
// [R3] Bit 27 enables fine trim of the fast RC oscillator, reset 0.
// [R4] Six-bit fine trim (reset 0x1f) acts only while enabled.
// [R5] Regulator high-power bit 24 resets to 1.
// [R6] Software loads the aux register with factory values.
// [R7] Software may retune trims and divider to reach other frequencies.
// [R8] Aux register has a sync-pending flag; write only while it is 0.
// [R9] Auto-start bit 29 starts the crystal on active entry and switches.
// [R10] System stays on fast RC until crystal ready; bit writable anytime.
// [R11] Software writes zeros to reserved bits.
// [R12] Fast RC register has a sync-pending flag; write only while 0.
// [R13] Changing fast RC fields gives no glitch on its output clock.
module otc_regs (
    input  wire logic                 sys_clk,
    input  wire logic                 nrst,
    input  wire logic [11:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [11:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 active_power_states,
    input  wire logic                 xtal_ready,
    input  wire logic                 fast_rc_tick,
    input  wire logic                 aux_rc_tick,
    output otc_pkg::otc_rc_trim_t     fast_rc_trim,
    output otc_pkg::otc_rc_trim_t     aux_rc_trim,
    output logic [5:0]                fast_rc_fine_eff,
    output logic [5:0]                aux_rc_fine_eff,
    output logic [31:0]               slow_rc_ctrl,
    output logic                      fast_rc_div_tick,
    output logic                      aux_rc_div_tick,
    output logic                      xtal_enable,
    output logic                      sysclk_on_xtal
);
    import otc_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] fast_ctrl_ff, aux_ctrl_ff, slow_ctrl_ff, xtal_ctrl_ff;
    logic [2:0]  fast_sync_ff, aux_sync_ff;
    logic        aw_hold_ff, w_hold_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        bvalid_ff, rvalid_ff;
    logic [1:0]  bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic        active_ff;
    otc_auto_t   auto_ff, nxt_auto;
    logic [1:0]  fast_cnt_ff, aux_cnt_ff;
    logic        fast_div_ff, aux_div_ff;
    logic        do_write;

    // Merge byte lanes, keeping reserved bits at zero
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb,
                                          input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction

    // Divider terminal count for a code
    function automatic logic [1:0] div_last(input logic [1:0] code);
        case (code)
            OTC_DIV_TWO:  div_last = 2'h1;
            OTC_DIV_FOUR: div_last = 2'h3;
            default:      div_last = 2'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Write channel: address and data taken in any order
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
    assign do_write      = aw_hold_ff && w_hold_ff && !bvalid_ff;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff  <= 1'b0;
            awaddr_ff  <= 12'h000;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold_ff <= 1'b0;
            end
        end
    end

    // Register update and write response
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fast_ctrl_ff <= OTC_RC_RESET;     // [R1] [R3] [R4] [R5]
            aux_ctrl_ff  <= OTC_RC_RESET;     // [R2]
            slow_ctrl_ff <= OTC_SLOW_RESET;
            xtal_ctrl_ff <= OTC_XTAL_RESET;
            bvalid_ff    <= 1'b0;
            bresp_ff     <= OTC_RESP_OKAY;
        end else begin
            if (do_write) begin
                bvalid_ff <= 1'b1;
                bresp_ff  <= OTC_RESP_OKAY;
                case ({awaddr_ff[11:2], 2'b00})
                    OTC_OFF_FAST_RC: fast_ctrl_ff <= merge(fast_ctrl_ff,
                        wdata_ff, wstrb_ff, OTC_RC_MASK);
                    OTC_OFF_AUX_RC:  aux_ctrl_ff <= merge(aux_ctrl_ff,
                        wdata_ff, wstrb_ff, OTC_RC_MASK);
                    OTC_OFF_SLOW_RC: slow_ctrl_ff <= merge(slow_ctrl_ff,
                        wdata_ff, wstrb_ff, OTC_SLOW_MASK);
                    // Auto-start bits are writable anytime; bit 29 acts on the next active entry
                    OTC_OFF_XTAL:    xtal_ctrl_ff <= merge(xtal_ctrl_ff,
                        wdata_ff, wstrb_ff, OTC_XTAL_MASK); // [R10]
                    OTC_OFF_STATUS:  bresp_ff <= OTC_RESP_OKAY;
                    OTC_OFF_POWER:   bresp_ff <= OTC_RESP_OKAY;
                    default:         bresp_ff <= OTC_RESP_SLVERR;
                endcase
            end else if (s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // ------------------------------------------------------------
    // Sync pending: a down-counter that models transfer to the oscillator
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fast_sync_ff <= 3'h0;
            aux_sync_ff  <= 3'h0;
        end else begin
            if (do_write && {awaddr_ff[11:2], 2'b00} == OTC_OFF_FAST_RC)
                fast_sync_ff <= 3'(OTC_SYNC_CYCLES - 1);     // [R12]
            else if (fast_sync_ff != 3'h0)
                fast_sync_ff <= fast_sync_ff - 3'h1;
            if (do_write && {awaddr_ff[11:2], 2'b00} == OTC_OFF_AUX_RC)
                aux_sync_ff <= 3'(OTC_SYNC_CYCLES - 1);      // [R8]
            else if (aux_sync_ff != 3'h0)
                aux_sync_ff <= aux_sync_ff - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    assign s_axi_arready = !rvalid_ff;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= OTC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= OTC_RESP_OKAY;
            case ({s_axi_araddr[11:2], 2'b00})
                OTC_OFF_FAST_RC: rdata_ff <= fast_ctrl_ff;
                OTC_OFF_AUX_RC:  rdata_ff <= aux_ctrl_ff;
                OTC_OFF_SLOW_RC: rdata_ff <= slow_ctrl_ff;
                OTC_OFF_XTAL:    rdata_ff <= xtal_ctrl_ff;
                OTC_OFF_STATUS:  rdata_ff <= {28'h0, sysclk_on_xtal,
                    xtal_enable, aux_sync_ff != 3'h0,
                    fast_sync_ff != 3'h0};          // [R8] [R12]
                OTC_OFF_POWER:   rdata_ff <= {31'h0, active_ff};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= OTC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;

    // ------------------------------------------------------------
    // Crystal auto-start on entry into active states
    // ------------------------------------------------------------
    always_comb begin
        nxt_auto = auto_ff;
        case (auto_ff)
            OTC_AS_IDLE:
                if (active_power_states && !active_ff &&
                    xtal_ctrl_ff[OTC_AUTOSW_BIT])
                    nxt_auto = OTC_AS_START;                 // [R9]
            OTC_AS_START:
                if (!active_power_states)
                    nxt_auto = OTC_AS_IDLE;
                else if (xtal_ready)
                    nxt_auto = OTC_AS_SWAP;                  // [R10]
            OTC_AS_SWAP:
                if (!active_power_states)
                    nxt_auto = OTC_AS_IDLE;
            default: nxt_auto = OTC_AS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            auto_ff   <= OTC_AS_IDLE;
            active_ff <= 1'b0;
        end else begin
            auto_ff   <= nxt_auto;
            active_ff <= active_power_states;
        end
    end
    assign xtal_enable    = auto_ff != OTC_AS_IDLE;
    assign sysclk_on_xtal = auto_ff == OTC_AS_SWAP;          // [R10]

    // ------------------------------------------------------------
    // Output dividers; counters restart once at or past the terminal count
    // so a smaller new setting never lets the count run past it and wrap
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fast_cnt_ff <= 2'h0;
            aux_cnt_ff  <= 2'h0;
            fast_div_ff <= 1'b0;
            aux_div_ff  <= 1'b0;
        end else begin
            fast_div_ff <= 1'b0;
            aux_div_ff  <= 1'b0;
            if (fast_rc_tick) begin
                if (fast_cnt_ff >= div_last(
                        fast_ctrl_ff[OTC_DIV_LSB +: 2])) begin // [R13]
                    fast_cnt_ff <= 2'h0;
                    fast_div_ff <= 1'b1;                     // [R1]
                end else begin
                    fast_cnt_ff <= fast_cnt_ff + 2'h1;
                end
            end
            if (aux_rc_tick) begin
                if (aux_cnt_ff >= div_last(
                        aux_ctrl_ff[OTC_DIV_LSB +: 2])) begin
                    aux_cnt_ff <= 2'h0;
                    aux_div_ff <= 1'b1;                      // [R2]
                end else begin
                    aux_cnt_ff <= aux_cnt_ff + 2'h1;
                end
            end
        end
    end
    assign fast_rc_div_tick = fast_div_ff;
    assign aux_rc_div_tick  = aux_div_ff;
    assign slow_rc_ctrl     = slow_ctrl_ff;

    // Field unpack for both RC oscillators
    otc_rc_field u_fast (
        .ctrl_word (fast_ctrl_ff),
        .trim      (fast_rc_trim),
        .eff_fine  (fast_rc_fine_eff)    // [R3]
    );
    otc_rc_field u_aux (
        .ctrl_word (aux_ctrl_ff),
        .trim      (aux_rc_trim),
        .eff_fine  (aux_rc_fine_eff)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_fine_gated: assert property (                          // [R4]
        !fast_rc_trim.fine_trim_enable |-> fast_rc_fine_eff == 6'h00)
        else $error("fine trim leaks while disabled");
    a_fine_pass: assert property (                           // [R3]
        fast_rc_trim.fine_trim_enable |->
        fast_rc_fine_eff == fast_rc_trim.fine_trim_value)
        else $error("fine trim not applied");
    a_div_one_tick: assert property (                        // [R1]
        fast_rc_tick && fast_rc_trim.osc_output_divider == OTC_DIV_ONE
        && fast_cnt_ff == 2'h0 |=> fast_rc_div_tick)
        else $error("divide by one missed a tick");
    // Pulse launched under the old code is left out after a change
    a_div_four_gap: assert property (                        // [R1]
        fast_rc_div_tick && fast_rc_trim.osc_output_divider ==
        OTC_DIV_FOUR && $past(fast_rc_trim.osc_output_divider) ==
        OTC_DIV_FOUR |-> !$past(fast_div_ff))
        else $error("divide by four too fast");
    // Code must have stood two cycles so the count is settled
    a_aux_div_two: assert property (                         // [R2]
        aux_rc_div_tick && aux_rc_trim.osc_output_divider == OTC_DIV_TWO
        && $past(aux_rc_trim.osc_output_divider) == OTC_DIV_TWO
        && $past(aux_rc_trim.osc_output_divider, 2) == OTC_DIV_TWO
        |-> $past(aux_cnt_ff) == 2'h1)
        else $error("aux divide by two wrong");
    a_aux_sync_busy: assert property (                       // [R8]
        do_write && {awaddr_ff[11:2], 2'b00} == OTC_OFF_AUX_RC
        |=> (aux_sync_ff != 3'h0) [*3] ##1 aux_sync_ff == 3'h0)
        else $error("aux sync pending length wrong");
    a_fast_sync_busy: assert property (                      // [R12]
        do_write && {awaddr_ff[11:2], 2'b00} == OTC_OFF_FAST_RC
        |=> fast_sync_ff == 3'(OTC_SYNC_CYCLES - 1))
        else $error("fast sync pending not raised");
    a_auto_start: assert property (                          // [R9]
        auto_ff == OTC_AS_IDLE && active_power_states && !active_ff &&
        xtal_ctrl_ff[OTC_AUTOSW_BIT] |=> xtal_enable && !sysclk_on_xtal)
        else $error("auto start did not start crystal");
    a_stay_on_rc: assert property (                          // [R10]
        $rose(sysclk_on_xtal) |-> $past(xtal_ready))
        else $error("switched before crystal ready");

    c_auto_swap: cover property ($rose(sysclk_on_xtal));
    c_fast_write: cover property (fast_sync_ff != 3'h0);
    c_div_four: cover property (fast_rc_div_tick &&
        fast_rc_trim.osc_output_divider == OTC_DIV_FOUR);

endmodule

// [tb/oscillator_trim_control_regs_tb.sv]
/*
 * Self-checking bench for the oscillator trim control registers.
 * Assumes otc_pkg and otc_regs are compiled first; bench is bus master.
 */
`timescale 1ns/1ps
module oscillator_trim_control_regs_tb;
    import otc_pkg::*;

    logic         sys_clk, nrst, active_power_states, xtal_ready;
    logic [11:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0]  s_axi_wdata, s_axi_rdata, slow_rc_ctrl, rd;
    logic [3:0]   s_axi_wstrb;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
    logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic         s_axi_rvalid, s_axi_rready, xtal_enable, sysclk_on_xtal;
    logic         fast_rc_tick, aux_rc_tick, fast_rc_div_tick, aux_rc_div_tick;
    logic [5:0]   fast_rc_fine_eff, aux_rc_fine_eff;
    otc_rc_trim_t fast_rc_trim, aux_rc_trim;
    logic [11:0]  adr;
    int           fail_count, num_checks, cycles, gap;

    otc_regs i_dut (
        .sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .active_power_states, .xtal_ready,
        .fast_rc_tick, .aux_rc_tick, .fast_rc_trim, .aux_rc_trim,
        .fast_rc_fine_eff, .aux_rc_fine_eff, .slow_rc_ctrl,
        .fast_rc_div_tick, .aux_rc_div_tick, .xtal_enable, .sysclk_on_xtal
    );

    // ----------------------------------------------------------------
    // Clock and hang guard
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Whole run is well under a thousand cycles; this cuts a hang short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Address and data offered together; bready stays high throughout
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit aw_t, w_t;
        aw_t = 1'b0;
        w_t = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (!aw_t && s_axi_awready === 1'b1) begin
                aw_t = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_t && s_axi_wready === 1'b1) begin
                w_t = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_t && w_t));
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
    endtask

    task automatic rdw(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    // Polls the status word until both sync flags are clear
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            rdw(OTC_OFF_STATUS);
            n++;
        end while (rd[1:0] !== 2'h0 && n < 20);
        chk("sync pending", 32'h0, {30'h0, rd[1:0]});
    endtask

    // Second gap is taken: the first may still carry the old count
    task automatic div_gap(input bit aux);
        repeat (2) begin
            gap = 0;
            do @(posedge sys_clk);
            while ((aux ? aux_rc_div_tick : fast_rc_div_tick) !== 1'b1);
            do begin
                @(posedge sys_clk);
                gap++;
            end while ((aux ? aux_rc_div_tick : fast_rc_div_tick) !== 1'b1
                       && gap < 20);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        {nrst, active_power_states, xtal_ready, fast_rc_tick} = 4'h0;
        {aux_rc_tick, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
        {fail_count, num_checks, cycles} = '0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rdw(OTC_OFF_FAST_RC);
        chk("fast reset", 32'hb148_1f3c, rd);
        rdw(OTC_OFF_AUX_RC);
        chk("aux reset", 32'hb148_1f3c, rd);
        rdw(OTC_OFF_XTAL);
        chk("xtal reset", 32'h0, rd);
        chk("slow reset", 32'h8106_0100, slow_rc_ctrl);
        chk("aux div", 32'h0, {30'h0, aux_rc_trim.osc_output_divider});
        chk("fine off", 32'h0, {26'h0, fast_rc_fine_eff});
        $display("test reset values done");
        // Fine value acts only with its enable set, on both oscillators
        for (int i = 0; i < 2; i++) begin
            adr = i ? OTC_OFF_AUX_RC : OTC_OFF_FAST_RC;
            wait_idle();
            wr(adr, 32'hb148_2a3c);
            chk("fine gated", 32'h0, {26'h0, i ? aux_rc_fine_eff
                                              : fast_rc_fine_eff});
            wait_idle();
            wr(adr, 32'hb948_2a3c);
            chk("fine on", 32'h2a, {26'h0, i ? aux_rc_fine_eff
                                            : fast_rc_fine_eff});
        end
        $display("test fine trim done");
        wait_idle();
        wr(OTC_OFF_FAST_RC, 32'hffff_ffff);
        rdw(OTC_OFF_STATUS);
        chk("sync busy", 32'h1, {30'h0, rd[1:0]});
        rdw(OTC_OFF_FAST_RC);
        chk("reserved zero", 32'hffff_3f7f, rd);
        wr(12'h0fc, 32'h1234_5678);
        chk("bad write resp", {30'h0, OTC_RESP_SLVERR}, {30'h0, rsp});
        rdw(12'h0fc);
        chk("bad read data", 32'h0, rd);
        chk("bad read resp", {30'h0, OTC_RESP_SLVERR}, {30'h0, rsp});
        $display("test reserved and unmapped done");
        fast_rc_tick <= 1'b1;
        aux_rc_tick <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wait_idle();
            wr(i[0] ? OTC_OFF_AUX_RC : OTC_OFF_FAST_RC,
               32'hb148_1f3c | (i[2:1] << OTC_DIV_LSB));
            div_gap(i[0]);
            chk("divider gap", 32'h1 << i[2:1], gap);
        end
        $display("test dividers done");
        active_power_states <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("no auto start", 32'h0, {30'h0, xtal_enable, sysclk_on_xtal});
        wr(OTC_OFF_XTAL, 32'h2000_0000);
        rdw(OTC_OFF_XTAL);
        chk("auto bit", 32'h2000_0000, rd);
        active_power_states <= 1'b0;
        repeat (3) @(posedge sys_clk);
        active_power_states <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk("start on rc", 32'h2, {30'h0, xtal_enable, sysclk_on_xtal});
        xtal_ready <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("switched", 32'h3, {30'h0, xtal_enable, sysclk_on_xtal});
        active_power_states <= 1'b0;
        repeat (4) @(posedge sys_clk);
        active_power_states <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk("wake switch", 32'h3, {30'h0, xtal_enable, sysclk_on_xtal});
        $display("test auto start done");
        close_out();
    end
endmodule
